//--- hw/stc3_clk_front.sv
// Purpose: picks and prescales the count clock source
// Assumes: external clock is sampled by i_clk
// Notes: async mode samples raw level once; edges still land in i_clk
`timescale 1ns/1ps
`include "stc3_defs.svh"
module stc3_clk_front (
   input  wire logic   i_clk,
   input  wire logic   i_resetn,
   input  wire logic   i_ext_clk,
   input  wire logic   i_ext_src,
   input  wire logic   i_no_sync,
   input  wire logic   i_run,
   input  wire logic   i_ps_clr,
   input  wire logic [1:0] i_ps_sel,
   stc3_tick_if.src    tick_o
);
   import stc3_pkg::*;
   typedef struct packed {
      logic       s1;
      logic       s2;
      logic       prev;
      logic       armed;
      logic [1:0] idiv;
      logic [2:0] ps;
      logic       tick;
   } stc3_front_t;
   stc3_front_t st_q, st_d;
   logic raw, rise;

   always_comb begin
      st_d      = st_q;
      st_d.s1   = i_ext_clk;
      st_d.s2   = st_q.s1;
      raw       = i_no_sync ? i_ext_clk : st_q.s2;
      st_d.prev = raw;
      rise      = 1'b0;
      st_d.tick = 1'b0;
      if (!raw && st_q.prev) begin
         st_d.armed = 1'b1;
      end
      st_d.idiv = st_q.idiv + 2'h1;
      if (!i_ext_src) begin
         rise       = (st_q.idiv == `STC3_INSTR_DIV);
         st_d.armed = 1'b0;
      end else begin
         rise = raw && !st_q.prev && st_q.armed;
      end
      // divide by 1, 2, 4 or 8
      if (i_ps_clr) begin
         st_d.ps = 3'h0;
      end else if (i_run && rise) begin
         st_d.ps = st_q.ps + 3'h1;
         unique case (i_ps_sel)
            2'h0: st_d.tick = 1'b1;
            2'h1: st_d.tick = st_q.ps[0];
            2'h2: st_d.tick = &st_q.ps[1:0];
            2'h3: st_d.tick = &st_q.ps;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign tick_o.tick = st_q.tick;
   // mode from source and sync bits
   assign tick_o.mode = !i_ext_src ? STC3_MODE_TIMER :
                        (i_no_sync ? STC3_MODE_ASYNC : STC3_MODE_SYNC);

   ps_one_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_run && rise && !i_ps_clr && i_ps_sel == 2'h0) |=> st_q.tick)
      else $error("prescale 1:1 tick missing");
   int_space_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (!i_ext_src && rise) |=> !rise [*3])
      else $error("internal tick too frequent");
   ext_arm_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_ext_src && !st_q.armed) |-> !rise)
      else $error("external edge counted before arming");
   sync_two_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      ##1 st_q.s2 == $past(st_q.s1))
      else $error("sync second stage wrong");
endmodule : stc3_clk_front

//--- hw/stc3_defs.svh
// Purpose: constants for the sixteen-bit timer/counter three block
// Assumes: axi4-lite, 32-bit data, one register per aligned word
// Notes: offsets are byte addresses
`ifndef STC3_DEFS_SVH
`define STC3_DEFS_SVH
`define STC3_OFF_CTRL    4'h0
`define STC3_OFF_LOW     4'h4
`define STC3_OFF_HIGH    4'h8
`define STC3_OFF_IRQ     4'hC
`define STC3_CTRL_RESET  8'h00
`define STC3_BIT_WIDE    7
`define STC3_BIT_RTHI    6
`define STC3_BIT_PS1     5
`define STC3_BIT_PS0     4
`define STC3_BIT_RTLO    3
`define STC3_BIT_NOSYNC  2
`define STC3_BIT_EXTSRC  1
`define STC3_BIT_ON      0
`define STC3_IRQ_FLAG    0
`define STC3_IRQ_EN      1
`define STC3_IRQ_OSC     2
`define STC3_INSTR_DIV   2'h3
`define STC3_COUNT_MAX   16'hFFFF
`define STC3_RESP_OKAY   2'h0
`define STC3_RESP_DECERR 2'h3
`endif

//--- hw/stc3_pkg.sv
// Purpose: types for the timer/counter three block
// Assumes: constants live in stc3_defs.svh
// Notes: none
package stc3_pkg;
   typedef enum logic [1:0] {
      STC3_MODE_TIMER,
      STC3_MODE_SYNC,
      STC3_MODE_ASYNC
   } stc3_mode_t;
   typedef logic [7:0]  stc3_byte_t;
   typedef logic [15:0] stc3_count_t;
endpackage : stc3_pkg

//--- hw/stc3_tick_if.sv
// Purpose: tick link from the clock front end to the counter core
// Assumes: single clock
// Notes: tick is a one-cycle enable
`timescale 1ns/1ps
interface stc3_tick_if;
   logic tick;
   stc3_pkg::stc3_mode_t mode;
   modport src (output tick, output mode);
   modport dst (input tick, input mode);
endinterface : stc3_tick_if

//--- hw/stc3_timer.sv
// Purpose: sixteen-bit timer/counter three with axi4-lite registers
// Assumes: synchronous active-low reset; 10 MHz clock
// Notes: count bytes and irq bits sit in words of their own
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "stc3_defs.svh"
module stc3_timer (
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   input  wire logic [3:0]  i_s_awaddr,
   input  wire logic        i_s_awvalid,
   output logic             o_s_awready,
   input  wire logic [31:0] i_s_wdata,
   input  wire logic [3:0]  i_s_wstrb,
   input  wire logic        i_s_wvalid,
   output logic             o_s_wready,
   output logic [1:0]       o_s_bresp,
   output logic             o_s_bvalid,
   input  wire logic        i_s_bready,
   input  wire logic [3:0]  i_s_araddr,
   input  wire logic        i_s_arvalid,
   output logic             o_s_arready,
   output logic [31:0]      o_s_rdata,
   output logic [1:0]       o_s_rresp,
   output logic             o_s_rvalid,
   input  wire logic        i_s_rready,
   input  wire logic        i_ext_clk,
   input  wire logic        i_special_event,
   output logic             o_irq,
   output logic             o_osc_pins_input,
   output logic             o_std_uses_this,
   output logic             o_enh_uses_this,
   output stc3_pkg::stc3_count_t o_count
);
   import stc3_pkg::*;

   typedef struct packed {
      logic        awr;
      logic [3:0]  awa;
      logic        wr;
      logic [31:0] wd;
      logic [3:0]  ws;
      logic        bv;
      logic [1:0]  br;
      logic        rv;
      logic [31:0] rd;
      logic [1:0]  rr;
      stc3_byte_t  ctrl;
      stc3_count_t cnt;
      stc3_byte_t  hbuf;
      logic        flag;
      logic        ien;
      logic        osc;
      logic        irq;
      logic        std;
      logic        enh;
   } stc3_state_t;
   stc3_state_t st_q, st_d;

   stc3_tick_if tk ();
   logic do_wr, do_rd, wr_low, wr_high, wr_ctrl, rd_low, wide, ps_clr;
   logic wrap, step, wr_live;

   function automatic logic addr_ok(input logic [3:0] a);
      addr_ok = (a == `STC3_OFF_CTRL) || (a == `STC3_OFF_LOW) ||
                (a == `STC3_OFF_HIGH) || (a == `STC3_OFF_IRQ);
   endfunction : addr_ok

   stc3_clk_front u_front (
      .i_clk     (i_clk),
      .i_resetn  (i_resetn),
      .i_ext_clk (i_ext_clk),
      .i_ext_src (st_q.ctrl[`STC3_BIT_EXTSRC]),
      .i_no_sync (st_q.ctrl[`STC3_BIT_NOSYNC]),
      .i_run     (st_q.ctrl[`STC3_BIT_ON]),
      .i_ps_clr  (ps_clr),
      .i_ps_sel  (st_q.ctrl[`STC3_BIT_PS1:`STC3_BIT_PS0]),
      .tick_o    (tk)
   );

   always_comb begin
      wide    = st_q.ctrl[`STC3_BIT_WIDE];
      do_wr   = st_q.awr && st_q.wr && !st_q.bv;
      do_rd   = i_s_arvalid && !st_q.rv;
      wr_ctrl = do_wr && st_q.awa == `STC3_OFF_CTRL && st_q.ws[0];
      wr_low  = do_wr && st_q.awa == `STC3_OFF_LOW && st_q.ws[0];
      wr_high = do_wr && st_q.awa == `STC3_OFF_HIGH && st_q.ws[0];
      rd_low  = do_rd && i_s_araddr == `STC3_OFF_LOW;
      ps_clr  = wr_low;
      // a tick already in flight dies once the timer is switched off
      step    = tk.tick && st_q.ctrl[`STC3_BIT_ON];
      // a buffered high write leaves the live count alone, so it must not hide a wrap
      wr_live = wr_low || (wr_high && !wide);
      wrap    = step && st_q.cnt == `STC3_COUNT_MAX;
   end

   always_comb begin
      st_d = st_q;
      // write address and data taken in either order
      if (i_s_awvalid && !st_q.awr) begin
         st_d.awr = 1'b1;
         st_d.awa = i_s_awaddr;
      end
      if (i_s_wvalid && !st_q.wr) begin
         st_d.wr = 1'b1;
         st_d.wd = i_s_wdata;
         st_d.ws = i_s_wstrb;
      end
      if (st_q.bv && i_s_bready) begin
         st_d.bv = 1'b0;
      end
      if (do_wr) begin
         st_d.awr = 1'b0;
         st_d.wr  = 1'b0;
         st_d.bv  = 1'b1;
         st_d.br  = addr_ok(st_q.awa) ? `STC3_RESP_OKAY : `STC3_RESP_DECERR;
      end
      if (wr_ctrl) begin
         st_d.ctrl = st_q.wd[7:0];
      end

      if (step) begin
         st_d.cnt = st_q.cnt + 16'h0001;
      end
      if (i_special_event && tk.mode != STC3_MODE_ASYNC) begin
         st_d.cnt = '0;
      end
      if (wr_low) begin
         // in wide mode a low write loads high from buffer; byte mode keeps the live high byte
         st_d.cnt = wide ? {st_q.hbuf, st_q.wd[7:0]} : {st_q.cnt[15:8], st_q.wd[7:0]};
      end
      if (wr_high) begin
         // wide mode routes high writes to buffer
         if (wide) begin
            st_d.hbuf = st_q.wd[7:0];
         end else begin
            st_d.cnt[15:8] = st_q.wd[7:0];
         end
      end

      // sticky flag on wrap; trigger clear never sets it
      if (do_wr && st_q.awa == `STC3_OFF_IRQ && st_q.ws[0]) begin
         st_d.flag = st_q.wd[`STC3_IRQ_FLAG];
         st_d.ien  = st_q.wd[`STC3_IRQ_EN];
         st_d.osc  = st_q.wd[`STC3_IRQ_OSC];
      end
      // hardware set wins over a software clear in the same cycle
      if (wrap && !wr_live) begin
         st_d.flag = 1'b1;
      end
      st_d.irq = st_d.flag && st_d.ien;

      st_d.std = st_d.ctrl[`STC3_BIT_RTHI];
      st_d.enh = st_d.ctrl[`STC3_BIT_RTHI] || st_d.ctrl[`STC3_BIT_RTLO];

      if (st_q.rv && i_s_rready) begin
         st_d.rv = 1'b0;
      end
      if (do_rd) begin
         st_d.rv = 1'b1;
         st_d.rr = addr_ok(i_s_araddr) ? `STC3_RESP_OKAY : `STC3_RESP_DECERR;
         st_d.rd = '0;
         unique case (i_s_araddr)
            `STC3_OFF_CTRL: st_d.rd[7:0] = st_q.ctrl;
            `STC3_OFF_LOW:  st_d.rd[7:0] = st_q.cnt[7:0];
            `STC3_OFF_HIGH: st_d.rd[7:0] = wide ? st_q.hbuf : st_q.cnt[15:8];
            `STC3_OFF_IRQ:  st_d.rd[2:0] = {st_q.osc, st_q.ien, st_q.flag};
            default:        st_d.rd = '0;
         endcase
      end
      // in wide mode a low read latches live high byte
      if (rd_low && wide && !wr_high) begin
         st_d.hbuf = st_q.cnt[15:8];
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         st_q      <= '0;
         st_q.ctrl <= `STC3_CTRL_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   assign o_s_awready      = !st_q.awr;
   assign o_s_wready       = !st_q.wr;
   assign o_s_bvalid       = st_q.bv;
   assign o_s_bresp        = st_q.br;
   assign o_s_arready      = !st_q.rv;
   assign o_s_rvalid       = st_q.rv;
   assign o_s_rdata        = st_q.rd;
   assign o_s_rresp        = st_q.rr;
   assign o_irq            = st_q.irq;
   assign o_osc_pins_input = st_q.osc;
   assign o_std_uses_this  = st_q.std;
   assign o_enh_uses_this  = st_q.enh;
   assign o_count          = st_q.cnt;

   sequence wrap_seq;
      wrap && !wr_live;
   endsequence

   wrap_flag_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      wrap_seq |=> st_q.flag && st_q.cnt == 16'h0000)
      else $error("wrap did not set flag");
   irq_gate_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_irq == (st_q.flag && st_q.ien))
      else $error("irq gating wrong");
   off_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (!st_q.ctrl[`STC3_BIT_ON] && !do_wr && !i_special_event) |=> $stable(st_q.cnt))
      else $error("count moved while off");
   trig_clr_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_special_event && tk.mode != STC3_MODE_ASYNC && !wr_low && !wr_high)
      |=> st_q.cnt == 16'h0000)
      else $error("trigger did not clear count");
   wr_wins_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_special_event && wr_low && !wide) |=> st_q.cnt[7:0] == $past(st_q.wd[7:0]))
      else $error("trigger beat software write");
   trig_flag_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_special_event && !st_q.flag && !wrap && !do_wr) |=> !st_q.flag)
      else $error("trigger set overflow flag");
   rd_latch_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (rd_low && wide && !wr_high) |=> st_q.hbuf == $past(st_q.cnt[15:8]))
      else $error("high buffer not latched");
   route_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (o_std_uses_this == st_q.ctrl[`STC3_BIT_RTHI]) &&
      (o_enh_uses_this == (st_q.ctrl[`STC3_BIT_RTHI] || st_q.ctrl[`STC3_BIT_RTLO])))
      else $error("timebase routing wrong");
   // byte mode high write goes live
   byte_hi_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (wr_high && !wide) |=> st_q.cnt[15:8] == $past(st_q.wd[7:0]))
      else $error("byte mode high write lost");
endmodule : stc3_timer

//--- tb/stc3_ext_src.sv
// Purpose: external count clock source for timer three
// Assumes: bench commands bursts of pulses
// Notes: line idles high and stands still between bursts
`timescale 1ns/1ps
module stc3_ext_src (
   input  wire logic i_clk,
   output logic      o_ext_clk
);
   initial o_ext_clk = 1'b1;
   // parks the line at a level between bursts
   task automatic level(input logic v);
      @(posedge i_clk);
      o_ext_clk <= v;
   endtask : level
   task automatic pulses(input int n, input int hw);
      repeat (n) begin
         repeat (hw) @(posedge i_clk);
         o_ext_clk <= 1'b0;
         repeat (hw) @(posedge i_clk);
         o_ext_clk <= 1'b1;
      end
   endtask : pulses
endmodule : stc3_ext_src

//--- tb/tb.sv
// Purpose: self-checking bench for timer three
// Assumes: axi4-lite master, 10 MHz clock
// Notes: count windows allow a few cycles of write latency
`timescale 1ns/1ps
`include "stc3_defs.svh"
module tb;
   import stc3_pkg::*;
   logic        clk, rstn, awvalid, wvalid, bready, arvalid, rready, ext_clk, sev;
   logic        awready, wready, bvalid, arready, rvalid, irq, osc_in, std_u, enh_u;
   logic [3:0]  awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp;
   stc3_count_t cnt, held;
   int          n_errors, checks;

   stc3_timer dut_u (.i_clk(clk), .i_resetn(rstn), .i_s_awaddr(awaddr),
      .i_s_awvalid(awvalid), .o_s_awready(awready), .i_s_wdata(wdata), .i_s_wstrb(wstrb),
      .i_s_wvalid(wvalid), .o_s_wready(wready), .o_s_bresp(bresp), .o_s_bvalid(bvalid),
      .i_s_bready(bready), .i_s_araddr(araddr), .i_s_arvalid(arvalid),
      .o_s_arready(arready), .o_s_rdata(rdata), .o_s_rresp(rresp), .o_s_rvalid(rvalid),
      .i_s_rready(rready), .i_ext_clk(ext_clk), .i_special_event(sev), .o_irq(irq),
      .o_osc_pins_input(osc_in), .o_std_uses_this(std_u), .o_enh_uses_this(enh_u),
      .o_count(cnt));
   stc3_ext_src ext_u (.i_clk(clk), .o_ext_clk(ext_clk));

   always #50 clk = ~clk;

   task automatic close_out;
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : close_out

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("FAIL %s exp %h got %h", nm, e, g);
      end
   endtask : chk

   task automatic chk_rng(input string nm, input logic [15:0] lo, input logic [15:0] hi);
      checks++;
      if ((cnt >= lo && cnt <= hi) !== 1'b1) begin
         n_errors++;
         $display("FAIL %s exp %h..%h got %h", nm, lo, hi, cnt);
      end
   endtask : chk_rng

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      int k;
      @(posedge clk);
      awaddr <= a;
      wdata <= {24'h000000, d};
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (k = 0; k < 40; k++) begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      if (k == 40) begin
         n_errors++;
         close_out;
      end
      chk("bresp", 32'(`STC3_RESP_OKAY), 32'(bresp));
   endtask : wr

   task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] e,
                       input logic [1:0] er);
      int k;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (k = 0; k < 40; k++) begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      if (k == 40) begin
         n_errors++;
         close_out;
      end
      chk(nm, e, rdata);
      chk("rresp", 32'(er), 32'(rresp));
   endtask : rchk

   task automatic t_reset;
      rchk("ctrl", `STC3_OFF_CTRL, 32'(`STC3_CTRL_RESET), `STC3_RESP_OKAY);
      rchk("irq", `STC3_OFF_IRQ, 32'h0, `STC3_RESP_OKAY);
      rchk("hole", 4'h2, 32'h0, `STC3_RESP_DECERR);
      chk("count", 32'h0, 32'(cnt));
   endtask : t_reset

   task automatic t_route;
      logic [1:0] v;
      for (int i = 0; i < 4; i++) begin
         v = 2'(i);
         wr(`STC3_OFF_CTRL, {1'b0, v[1], 2'b00, v[0], 3'b000});
         repeat (2) @(posedge clk);
         chk("std", 32'(v[1]), 32'(std_u));
         chk("enh", 32'(v[1] | v[0]), 32'(enh_u));
      end
      wr(`STC3_OFF_IRQ, 8'h04);
      repeat (2) @(posedge clk);
      chk("osc", 32'h1, 32'(osc_in));
      wr(`STC3_OFF_IRQ, 8'h00);
   endtask : t_route

   // internal source, every prescale, sync-disable ignored at 1:1
   task automatic t_prescale;
      logic [1:0]  ps;
      logic [15:0] e;
      for (int i = 0; i < 4; i++) begin
         ps = 2'(i);
         e = 16'h0050 >> i;
         wr(`STC3_OFF_CTRL, 8'h00);
         wr(`STC3_OFF_LOW, 8'h00);
         wr(`STC3_OFF_HIGH, 8'h00);
         wr(`STC3_OFF_CTRL, {2'b00, ps, 1'b0, (i == 0), 2'b01});
         repeat (320) @(posedge clk);
         wr(`STC3_OFF_CTRL, 8'h00);
         chk_rng("ticks", e - 16'h1, e + 16'h2);
         held = cnt;
         repeat (40) @(posedge clk);
         chk("held", 32'(held), 32'(cnt));
         rchk("low", `STC3_OFF_LOW, 32'(held[7:0]), `STC3_RESP_OKAY);
      end
   endtask : t_prescale

   task automatic t_overflow;
      wr(`STC3_OFF_HIGH, 8'hFF);
      wr(`STC3_OFF_LOW, 8'hFC);
      wr(`STC3_OFF_CTRL, 8'h01);
      repeat (40) @(posedge clk);
      wr(`STC3_OFF_CTRL, 8'h00);
      chk_rng("wrap", 16'h0000, 16'h0008);
      chk("irq off", 32'h0, 32'(irq));
      rchk("flag", `STC3_OFF_IRQ, 32'h1, `STC3_RESP_OKAY);
      wr(`STC3_OFF_IRQ, 8'h03);
      repeat (2) @(posedge clk);
      chk("irq on", 32'h1, 32'(irq));
      wr(`STC3_OFF_IRQ, 8'h02);
      repeat (2) @(posedge clk);
      chk("irq clr", 32'h0, 32'(irq));
   endtask : t_overflow

   task automatic t_wide;
      wr(`STC3_OFF_CTRL, 8'h80);
      held = cnt;
      wr(`STC3_OFF_HIGH, 8'h12);
      repeat (2) @(posedge clk);
      chk("buffered", 32'(held), 32'(cnt));
      wr(`STC3_OFF_LOW, 8'h34);
      repeat (2) @(posedge clk);
      chk("both", 32'h1234, 32'(cnt));
      wr(`STC3_OFF_HIGH, 8'h77);
      rchk("wlow", `STC3_OFF_LOW, 32'h34, `STC3_RESP_OKAY);
      rchk("whigh", `STC3_OFF_HIGH, 32'h12, `STC3_RESP_OKAY);
   endtask : t_wide

   task automatic t_event;
      wr(`STC3_OFF_CTRL, 8'h01);
      repeat (20) @(posedge clk);
      sev <= 1'b1;
      @(posedge clk);
      sev <= 1'b0;
      repeat (2) @(posedge clk);
      chk_rng("cleared", 16'h0000, 16'h0002);
      wr(`STC3_OFF_CTRL, 8'h00);
      rchk("noflag", `STC3_OFF_IRQ, 32'h2, `STC3_RESP_OKAY);
      // trigger lands in the cycle the low-byte write is applied
      fork
         wr(`STC3_OFF_LOW, 8'h55);
         begin
            repeat (2) @(posedge clk);
            sev <= 1'b1;
            @(posedge clk);
            sev <= 1'b0;
         end
      join
      chk("wr wins", 32'h0055, 32'(cnt));
   endtask : t_event

   task automatic t_ext;
      wr(`STC3_OFF_LOW, 8'h00);
      wr(`STC3_OFF_HIGH, 8'h00);
      ext_u.level(1'b0);
      wr(`STC3_OFF_CTRL, 8'h03);
      // a rise with no falling edge before it must not count
      ext_u.level(1'b1);
      ext_u.pulses(10, 5);
      repeat (10) @(posedge clk);
      chk("sync", 32'h000A, 32'(cnt));
      wr(`STC3_OFF_CTRL, 8'h07);
      ext_u.pulses(10, 5);
      repeat (10) @(posedge clk);
      chk("async", 32'h0014, 32'(cnt));
   endtask : t_ext

   initial begin
      clk = 1'b0;
      rstn = 1'b0;
      {awaddr, araddr, wstrb, wdata} = '0;
      {awvalid, wvalid, bready, arvalid, rready, sev} = '0;
      n_errors = 0;
      checks = 0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      t_reset;
      t_route;
      t_prescale;
      t_overflow;
      t_wide;
      t_event;
      t_ext;
      close_out;
   end

   initial begin
      repeat (100000) @(posedge clk);
      n_errors++;
      close_out;
   end
endmodule : tb
